// >>> design/tcdma_top.v
// two-channel memory-to-memory dma engine with its byte fifo and banked registers
//
// Function
// - two independent channels, triggered by peripheral events or software requests
// - each channel has 16-bit source and destination pointers covering 64K bytes
// - count decrements per transfer; underflow sets channel flag and raises interrupt
// - both channels' underflow flags live in the shared index/status register
// - simultaneous requests: channel 0 always served before channel 1
// - each byte takes two clocks unless the write stalls: one source read, one destination write
// - shared register addresses; status bit 7 selects channel bank 0 or 1
// - mode one bit 0: source steps up when 0, down when 1
// - mode one bit 1: source pointer held when 0, stepped when 1
// - mode one bit 2: destination steps up when 0, down when 1
// - mode one bit 3: destination pointer held when 0, stepped when 1
// - mode one bit 4: 0 writes latches and working registers, 1 latches only
// - mode one bit 5 set: channel disables itself on count underflow
// - writing 1 to mode one bit 6 reloads pointers and count; reads 0
// - count underflow reloads pointers and count from reload latches automatically
// - mode one bit 7: 0 single byte per request, 1 burst
// - requests from usb, host bus, external, serial, timer sources and software
// - mode two four-bit source field picks hardware request; 0000 disables
// - writing 1 to soft trigger bit with enable bit 7 set in the same write raises one request; reads 0
// - mode two bit 7 enables channel; disabled channel ignores requests
// - usb tx packet-ready sources trigger falling edge, rx ones rising edge
`timescale 1ns/1ps
`include "tcdma_consts.vh"

module tcdma_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_i,
  input wire arst_n_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] fill;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  assign in_ready_o = (fill < DEPTH);
  assign out_valid_o = (fill != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];

  always @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      fill <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        fill <= fill + 1'b1;
      else if (pop && !push)
        fill <= fill - 1'b1;
    end
  end
endmodule // tcdma_fifo

module tcdma_top (
  input wire clk_i,
  input wire arst_n_i,
  input wire [3:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  input wire [15:1] periph_req_i,
  output wire [15:0] mem_addr_o,
  output wire mem_rd_o,
  input wire [7:0] mem_rdata_i,
  output wire mem_wr_o,
  input wire mem_wr_ready_i,
  output wire [7:0] mem_wdata_o,
  output reg [1:0] irq_o
);
  // ----------------------------------------------------------------
  // channel state
  // ----------------------------------------------------------------
  reg bank;
  reg [1:0] uf_flag;
  reg [7:0] mode_one [0:1];
  reg [7:0] mode_two [0:1];
  reg [15:0] src [0:1];
  reg [15:0] dst [0:1];
  reg [15:0] cnt [0:1];
  reg [15:0] src_rl [0:1];
  reg [15:0] dst_rl [0:1];
  reg [15:0] cnt_rl [0:1];
  reg [1:0] pend;
  reg [15:1] req_q;
  reg [2:0] state;
  reg cur;
  reg in_burst;
  integer c;
  integer h;

  function [15:0] step;
    input [15:0] val;
    input en;
    input dir;
    begin
      if (!en)
        step = val;
      else if (dir)
        step = val - 16'h0001;
      else
        step = val + 16'h0001;
    end
  endfunction

  // ----------------------------------------------------------------
  // request detection
  // ----------------------------------------------------------------
  // sources share one vector; usb tx ready codes look for the falling edge
  reg [1:0] hw_event;
  reg [3:0] sel;
  always @*
  begin
    hw_event = 2'b00;
    sel = 4'h0;
    for (h = 0; h < 2; h = h + 1)
    begin
      sel = mode_two[h][`TCDMA_M2_SRC_SEL_HI:0];
      if (sel != `TCDMA_SRC_NONE)
      begin
        if (sel >= `TCDMA_SRC_FALL_LO && sel <= `TCDMA_SRC_FALL_HI)
          hw_event[h] = req_q[sel] & ~periph_req_i[sel];
        else
          hw_event[h] = ~req_q[sel] & periph_req_i[sel];
      end
    end
  end

  wire bus_wr = reg_wr_i;
  wire [1:0] soft_trig;
  // a trigger written together with the enable bit must not be lost to the old enable
  assign soft_trig[0] = bus_wr && !bank && reg_addr_i == `TCDMA_OFF_MODE_TWO &&
                        reg_wdata_i[`TCDMA_M2_SOFT_TRIG] && reg_wdata_i[`TCDMA_M2_ENABLE];
  assign soft_trig[1] = bus_wr && bank && reg_addr_i == `TCDMA_OFF_MODE_TWO &&
                        reg_wdata_i[`TCDMA_M2_SOFT_TRIG] && reg_wdata_i[`TCDMA_M2_ENABLE];
  wire [1:0] ch_en;
  assign ch_en[0] = mode_two[0][`TCDMA_M2_ENABLE];
  assign ch_en[1] = mode_two[1][`TCDMA_M2_ENABLE];

  // ----------------------------------------------------------------
  // data path: read byte goes through the fifo to the write cycle
  // ----------------------------------------------------------------
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire is_read = (state == `TCDMA_ST_READ);
  wire is_write = (state == `TCDMA_ST_WRITE);
  // a stalled write holds the engine in the write state, so the fifo never holds more than one byte
  assign mem_rd_o = is_read & fifo_in_ready;
  assign mem_wr_o = is_write & fifo_out_valid;
  wire wr_done = mem_wr_o & mem_wr_ready_i;
  assign mem_addr_o = is_write ? dst[cur] : src[cur];

  tcdma_fifo #(
    .WIDTH(`TCDMA_FIFO_WIDTH),
    .DEPTH(`TCDMA_FIFO_DEPTH),
    .AW(`TCDMA_FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(mem_rd_o),
    .in_ready_o(fifo_in_ready),
    .in_data_i(mem_rdata_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(mem_wr_ready_i & is_write),
    .out_data_o(mem_wdata_o)
  );

  wire underflow = wr_done && cnt[cur] == 16'h0000;

  // ----------------------------------------------------------------
  // engine
  // ----------------------------------------------------------------
  wire [1:0] go = pend & ch_en;
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state <= `TCDMA_ST_IDLE;
      cur <= 1'b0;
      in_burst <= 1'b0;
    end
    else
    begin
      case (state)
        `TCDMA_ST_IDLE:
        begin
          if (go[0])
          begin
            cur <= 1'b0;
            in_burst <= mode_one[0][`TCDMA_M1_BURST];
            state <= `TCDMA_ST_READ;
          end
          else if (go[1])
          begin
            cur <= 1'b1;
            in_burst <= mode_one[1][`TCDMA_M1_BURST];
            state <= `TCDMA_ST_READ;
          end
        end
        `TCDMA_ST_READ:
        begin
          if (fifo_in_ready)
            state <= `TCDMA_ST_WRITE;
        end
        `TCDMA_ST_WRITE:
        begin
          if (wr_done)
          begin
            // burst keeps going while enabled and not yet underflowed
            if (in_burst && !underflow && ch_en[cur])
              state <= `TCDMA_ST_READ;
            else
              state <= `TCDMA_ST_IDLE;
          end
        end
        default:
          state <= `TCDMA_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers, pending requests and flags
  // ----------------------------------------------------------------
  wire [1:0] start;
  assign start[0] = (state == `TCDMA_ST_IDLE) && go[0];
  assign start[1] = (state == `TCDMA_ST_IDLE) && !go[0] && go[1];

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      bank <= 1'b0;
      uf_flag <= 2'b00;
      pend <= 2'b00;
      req_q <= 15'h0000;
      irq_o <= 2'b00;
      for (c = 0; c < 2; c = c + 1)
      begin
        mode_one[c] <= `TCDMA_RST_BYTE;
        mode_two[c] <= `TCDMA_RST_BYTE;
        src[c] <= `TCDMA_RST_WORD;
        dst[c] <= `TCDMA_RST_WORD;
        cnt[c] <= `TCDMA_RST_WORD;
        src_rl[c] <= `TCDMA_RST_WORD;
        dst_rl[c] <= `TCDMA_RST_WORD;
        cnt_rl[c] <= `TCDMA_RST_WORD;
      end
    end
    else
    begin
      req_q <= periph_req_i;
      irq_o <= 2'b00;
      // status flags: software writes 0 to clear, a new underflow wins
      if (bus_wr && reg_addr_i == `TCDMA_OFF_INDEX_STATUS)
      begin
        bank <= reg_wdata_i[`TCDMA_IS_BANK_BIT];
        uf_flag <= uf_flag & reg_wdata_i[`TCDMA_IS_FLAG1_BIT:`TCDMA_IS_FLAG0_BIT];
      end
      for (c = 0; c < 2; c = c + 1)
      begin
        // an accepted request is consumed at start; a new one arriving then is kept
        if (start[c])
          pend[c] <= 1'b0;
        if (soft_trig[c])
          pend[c] <= 1'b1;
        else if (!ch_en[c])
          pend[c] <= 1'b0;
        else if (hw_event[c])
          pend[c] <= 1'b1;
        // cpu writes to the selected bank
        if (bus_wr && bank == c[0])
        begin
          case (reg_addr_i)
            `TCDMA_OFF_MODE_ONE:
            begin
              mode_one[c] <= reg_wdata_i & 8'hbf;
              if (reg_wdata_i[`TCDMA_M1_RELOAD])
              begin
                src[c] <= src_rl[c];
                dst[c] <= dst_rl[c];
                cnt[c] <= cnt_rl[c];
              end
            end
            `TCDMA_OFF_MODE_TWO:
              mode_two[c] <= reg_wdata_i & 8'h8f;
            `TCDMA_OFF_SRC_LO:
            begin
              src_rl[c][7:0] <= reg_wdata_i;
              if (!mode_one[c][`TCDMA_M1_WR_TARGET])
                src[c][7:0] <= reg_wdata_i;
            end
            `TCDMA_OFF_SRC_HI:
            begin
              src_rl[c][15:8] <= reg_wdata_i;
              if (!mode_one[c][`TCDMA_M1_WR_TARGET])
                src[c][15:8] <= reg_wdata_i;
            end
            `TCDMA_OFF_DST_LO:
            begin
              dst_rl[c][7:0] <= reg_wdata_i;
              if (!mode_one[c][`TCDMA_M1_WR_TARGET])
                dst[c][7:0] <= reg_wdata_i;
            end
            `TCDMA_OFF_DST_HI:
            begin
              dst_rl[c][15:8] <= reg_wdata_i;
              if (!mode_one[c][`TCDMA_M1_WR_TARGET])
                dst[c][15:8] <= reg_wdata_i;
            end
            `TCDMA_OFF_CNT_LO:
            begin
              cnt_rl[c][7:0] <= reg_wdata_i;
              if (!mode_one[c][`TCDMA_M1_WR_TARGET])
                cnt[c][7:0] <= reg_wdata_i;
            end
            `TCDMA_OFF_CNT_HI:
            begin
              cnt_rl[c][15:8] <= reg_wdata_i;
              if (!mode_one[c][`TCDMA_M1_WR_TARGET])
                cnt[c][15:8] <= reg_wdata_i;
            end
            default:
            begin
            end
          endcase
        end
        // engine step after the write completes; it overrides a same-cycle cpu write
        if (wr_done && cur == c[0])
        begin
          if (underflow)
          begin
            src[c] <= src_rl[c];
            dst[c] <= dst_rl[c];
            cnt[c] <= cnt_rl[c];
            uf_flag[c] <= 1'b1;
            irq_o[c] <= 1'b1;
            if (mode_one[c][`TCDMA_M1_STOP_UF])
              mode_two[c][`TCDMA_M2_ENABLE] <= 1'b0;
          end
          else
          begin
            src[c] <= step(src[c], mode_one[c][`TCDMA_M1_SRC_EN],
                           mode_one[c][`TCDMA_M1_SRC_DIR]);
            dst[c] <= step(dst[c], mode_one[c][`TCDMA_M1_DST_EN],
                           mode_one[c][`TCDMA_M1_DST_DIR]);
            cnt[c] <= cnt[c] - 16'h0001;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register read-back, one clock after the read strobe
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      reg_rdata_o <= `TCDMA_RST_BYTE;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `TCDMA_OFF_INDEX_STATUS: reg_rdata_o <= {bank, 5'h00, uf_flag};
        `TCDMA_OFF_MODE_ONE: reg_rdata_o <= mode_one[bank];
        `TCDMA_OFF_MODE_TWO: reg_rdata_o <= mode_two[bank];
        `TCDMA_OFF_SRC_LO: reg_rdata_o <= src[bank][7:0];
        `TCDMA_OFF_SRC_HI: reg_rdata_o <= src[bank][15:8];
        `TCDMA_OFF_DST_LO: reg_rdata_o <= dst[bank][7:0];
        `TCDMA_OFF_DST_HI: reg_rdata_o <= dst[bank][15:8];
        `TCDMA_OFF_CNT_LO: reg_rdata_o <= cnt[bank][7:0];
        `TCDMA_OFF_CNT_HI: reg_rdata_o <= cnt[bank][15:8];
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule // tcdma_top

// >>> design/tcdma_consts.vh
// constants of the two-channel dma controller: register offsets, fields, resets, states
`ifndef TCDMA_CONSTS_VH
`define TCDMA_CONSTS_VH

// ----------------------------------------------------------------
// register offsets (byte registers behind the cpu sfr port)
// ----------------------------------------------------------------
`define TCDMA_OFF_INDEX_STATUS 4'h0
`define TCDMA_OFF_MODE_ONE 4'h1
`define TCDMA_OFF_MODE_TWO 4'h2
`define TCDMA_OFF_SRC_LO 4'h3
`define TCDMA_OFF_SRC_HI 4'h4
`define TCDMA_OFF_DST_LO 4'h5
`define TCDMA_OFF_DST_HI 4'h6
`define TCDMA_OFF_CNT_LO 4'h7
`define TCDMA_OFF_CNT_HI 4'h8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TCDMA_IS_BANK_BIT 7
`define TCDMA_IS_FLAG0_BIT 0
`define TCDMA_IS_FLAG1_BIT 1
`define TCDMA_M1_SRC_DIR 0
`define TCDMA_M1_SRC_EN 1
`define TCDMA_M1_DST_DIR 2
`define TCDMA_M1_DST_EN 3
`define TCDMA_M1_WR_TARGET 4
`define TCDMA_M1_STOP_UF 5
`define TCDMA_M1_RELOAD 6
`define TCDMA_M1_BURST 7
`define TCDMA_M2_SRC_SEL_HI 3
`define TCDMA_M2_SOFT_TRIG 4
`define TCDMA_M2_ENABLE 7

// ----------------------------------------------------------------
// reset values and request source codes
// ----------------------------------------------------------------
`define TCDMA_RST_BYTE 8'h00
`define TCDMA_RST_WORD 16'h0000
`define TCDMA_SRC_NONE 4'h0
`define TCDMA_SRC_FALL_LO 4'h5
`define TCDMA_SRC_FALL_HI 4'h7

// ----------------------------------------------------------------
// engine states, one-hot
// ----------------------------------------------------------------
`define TCDMA_ST_IDLE 3'b001
`define TCDMA_ST_READ 3'b010
`define TCDMA_ST_WRITE 3'b100

`define TCDMA_FIFO_WIDTH 8
`define TCDMA_FIFO_DEPTH 16
`define TCDMA_FIFO_AW 4

`endif

// >>> sim/tcdma_mem_model.sv
// behavioural memory beside the dma engine: predictable read bytes, stallable writes
`timescale 1ns/1ps
module tcdma_mem_model (
  input wire logic clk_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic mem_rd_i,
  input wire logic stall_i,
  output logic [7:0] mem_rdata_o,
  output logic mem_wr_ready_o
);
  logic [7:0] junk = 8'h00;
  // outside a read cycle the bus churns, so a late sample never sees a stale byte
  always @(posedge clk_i) junk <= junk + 8'h35;
  assign mem_rdata_o = mem_rd_i ? (mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ 8'h3c) : junk;
  assign mem_wr_ready_o = !stall_i;
endmodule // tcdma_mem_model

// >>> sim/tcdma_props.sv
// concurrent checks on the ports of the dma top
`timescale 1ns/1ps
`include "tcdma_consts.vh"
module tcdma_props (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [15:1] periph_req_i,
  input wire logic [15:0] mem_addr_o,
  input wire logic mem_rd_o,
  input wire logic [7:0] mem_rdata_i,
  input wire logic mem_wr_o,
  input wire logic mem_wr_ready_i,
  input wire logic [7:0] mem_wdata_o,
  input wire logic [1:0] irq_o
);
  logic done_q;
  logic done_qq;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // delayed write completions: an interrupt must trail the write that caused it
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      done_q <= 1'b0;
      done_qq <= 1'b0;
    end
    else
    begin
      done_q <= mem_wr_o & mem_wr_ready_i;
      done_qq <= done_q;
    end
  end
  a_read_then_write: assert property (mem_rd_o |=> mem_wr_o && !mem_rd_o)
    else $error("read cycle not followed by write cycle");
  a_no_overlap: assert property (!(mem_rd_o && mem_wr_o))
    else $error("read and write in one cycle");
  a_write_after_read: assert property ($rose(mem_wr_o) |-> $past(mem_rd_o))
    else $error("write cycle without a read before it");
  a_stall_holds: assert property (mem_wr_o && !mem_wr_ready_i |=>
    mem_wr_o && $stable(mem_addr_o) && $stable(mem_wdata_o)) else $error("stalled write moved");
  a_byte_pairs: assert property (mem_rd_o |=> mem_wdata_o == $past(mem_rdata_i))
    else $error("written byte differs from byte read");
  a_irq_pulse: assert property (irq_o != 2'b00 |=> (irq_o & $past(irq_o)) == 2'b00)
    else $error("interrupt longer than one cycle");
  a_irq_cause: assert property (irq_o != 2'b00 |-> done_q || done_qq)
    else $error("interrupt without a completed write");
  a_reload_reads0: assert property (reg_rd_i && reg_addr_i == `TCDMA_OFF_MODE_ONE |=>
    !reg_rdata_o[6]) else $error("reload bit read back set");
  a_trig_reads0: assert property (reg_rd_i && reg_addr_i == `TCDMA_OFF_MODE_TWO |=>
    reg_rdata_o[6:4] == 3'b000) else $error("trigger bits read back set");
  c_irq0: cover property (irq_o[0]);
  c_irq1: cover property (irq_o[1]);
  c_stall: cover property (mem_wr_o && !mem_wr_ready_i);
endmodule // tcdma_props

// >>> sim/tcdma_tb_top.sv
// self-checking bench for the two-channel dma engine
`timescale 1ns/1ps
`include "tcdma_consts.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module tcdma_tb_top;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [15:1] periph_req_i = 15'h0000;
  logic stall = 1'b0;
  logic stall_en = 1'b0;
  logic [31:0] seed = 32'd95251;
  wire [7:0] reg_rdata_o, mem_rdata_i, mem_wdata_o;
  wire [15:0] mem_addr_o;
  wire mem_rd_o, mem_wr_o, mem_wr_ready_i;
  wire [1:0] irq_o;
  logic [23:0] wq[$];
  int irq_cnt[2];
  int err_count = 0;
  int check_count = 0;
  int i;
  logic [7:0] b, m1;
  logic [15:0] s, d;
  logic [1:0] n;
  always #12.5 clk_i = ~clk_i;
  tcdma_top i_tcdma_top (.clk_i, .arst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .periph_req_i, .mem_addr_o, .mem_rd_o, .mem_rdata_i, .mem_wr_o,
    .mem_wr_ready_i, .mem_wdata_o, .irq_o);
  tcdma_mem_model i_tcdma_mem_model (.clk_i, .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
    .stall_i(stall), .mem_rdata_o(mem_rdata_i), .mem_wr_ready_o(mem_wr_ready_i));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [15:0] step(input logic [15:0] v, input logic en, input logic dn);
    return en ? (dn ? v - 16'h0001 : v + 16'h0001) : v;
  endfunction
  always @(posedge clk_i)
  begin
    seed <= lfsr(seed);
    stall <= stall_en & seed[3] & seed[9];
    if (mem_wr_o && mem_wr_ready_i) wq.push_back({mem_addr_o, mem_wdata_o});
    if (irq_o[0]) irq_cnt[0]++;
    if (irq_o[1]) irq_cnt[1]++;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
    #1 v = reg_rdata_o;
  endtask
  // v packs count, destination, source; pointers written before mode two starts the channel
  task automatic prog(input logic ch, input logic [47:0] v, input logic [7:0] a,
    input logic [7:0] c);
    int k;
    wr(`TCDMA_OFF_INDEX_STATUS, {ch, 7'h03});
    wr(`TCDMA_OFF_MODE_ONE, a);
    for (k = 0; k < 6; k++) wr(`TCDMA_OFF_SRC_LO + k[3:0], v[8*k +: 8]);
    wr(`TCDMA_OFF_MODE_TWO, c);
  endtask
  task automatic settle(input int n);
    int k;
    for (k = 0; k < 4000 && wq.size() < n; k++) @(posedge clk_i) #1;
    if (wq.size() < n)
    begin
      err_count++;
      test_done();
    end
  endtask
  task automatic moves(input logic [15:0] sa, input logic [15:0] da, input logic [7:0] a,
    input int n);
    int k;
    settle(n);
    for (k = 0; k < n; k++)
    begin
      `CHK(wq[k], {da, sa[7:0] ^ sa[15:8] ^ 8'h3c})
      sa = step(sa, a[1], a[0]);
      da = step(da, a[3], a[2]);
    end
    repeat (8) @(posedge clk_i);
    #1;
    `CHK(wq.size(), n)
    wq.delete();
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      rd(i[3:0], b);
      `CHK(b, 8'h00)
    end
    // write target left at 0 so the pointer write below reaches the working register
    wr(`TCDMA_OFF_MODE_ONE, 8'hef);
    rd(`TCDMA_OFF_MODE_ONE, b);
    `CHK(b, 8'haf)
    wr(`TCDMA_OFF_MODE_TWO, 8'h7f);
    rd(`TCDMA_OFF_MODE_TWO, b);
    `CHK(b, 8'h0f)
    `CHK(wq.size(), 0)
    wr(`TCDMA_OFF_SRC_LO, 8'ha5);
    wr(`TCDMA_OFF_INDEX_STATUS, 8'h83);
    rd(`TCDMA_OFF_SRC_LO, b);
    `CHK(b, 8'h00)
    wr(`TCDMA_OFF_INDEX_STATUS, 8'h03);
    rd(`TCDMA_OFF_SRC_LO, b);
    `CHK(b, 8'ha5)
    $display("test registers done");
    stall_en <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      s = seed[15:0];
      d = seed[31:16];
      n = seed[5:4];
      m1 = {2'b10, i[1], 1'b0, i[3:0]};
      irq_cnt = '{0, 0};
      prog(i[0], {14'h0000, n, d, s}, m1, 8'h90);
      moves(s, d, m1, n + 1);
      `CHK(irq_cnt[i[0]], 1)
      rd(`TCDMA_OFF_INDEX_STATUS, b);
      `CHK(b & 8'h83, {i[0], 5'h00, i[0], ~i[0]})
      rd(`TCDMA_OFF_SRC_LO, b);
      `CHK(b, s[7:0])
      rd(`TCDMA_OFF_MODE_TWO, b);
      `CHK(b, {~m1[5], 7'h00})
      wr(`TCDMA_OFF_INDEX_STATUS, {i[0], 7'h00});
    end
    $display("test bursts done");
    prog(1'b0, {16'h0001, 16'h2000, 16'h1000}, 8'h00, 8'h00);
    wr(`TCDMA_OFF_MODE_ONE, 8'h10);
    wr(`TCDMA_OFF_SRC_LO, 8'h77);
    rd(`TCDMA_OFF_SRC_LO, b);
    `CHK(b, 8'h00)
    wr(`TCDMA_OFF_MODE_ONE, 8'h4a);
    rd(`TCDMA_OFF_SRC_LO, b);
    `CHK(b, 8'h77)
    wr(`TCDMA_OFF_MODE_TWO, 8'h90);
    moves(16'h1077, 16'h2000, 8'h0a, 1);
    rd(`TCDMA_OFF_SRC_LO, b);
    `CHK(b, 8'h78)
    rd(`TCDMA_OFF_CNT_LO, b);
    `CHK(b, 8'h00)
    $display("test single done");
    for (i = 1; i < 16; i++)
    begin
      wr(`TCDMA_OFF_MODE_TWO, 8'h00);
      periph_req_i <= (i >= 5 && i <= 7) ? 15'h7fff : 15'h0000;
      prog(1'b0, {16'h0004, 16'h3000, 16'h4000}, 8'h0a, {4'h8, i[3:0]});
      periph_req_i[i] <= ~periph_req_i[i];
      moves(16'h4000, 16'h3000, 8'h0a, 1);
    end
    wr(`TCDMA_OFF_MODE_TWO, 8'h80);
    periph_req_i <= 15'h7fff;
    moves(16'h4000, 16'h3000, 8'h0a, 0);
    periph_req_i <= 15'h0000;
    prog(1'b1, {16'h0000, 16'h6000, 16'h5000}, 8'h00, 8'h81);
    prog(1'b0, {16'h0000, 16'h7000, 16'h5000}, 8'h00, 8'h81);
    periph_req_i[1] <= 1'b1;
    settle(2);
    `CHK(wq[0][23:8], 16'h7000)
    `CHK(wq[1][23:8], 16'h6000)
    $display("test requests done");
    test_done();
  end
endmodule // tcdma_tb_top
bind tcdma_top tcdma_props i_tcdma_props (.clk_i, .arst_n_i, .reg_addr_i, .reg_wr_i,
  .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .periph_req_i, .mem_addr_o, .mem_rd_o, .mem_rdata_i,
  .mem_wr_o, .mem_wr_ready_i, .mem_wdata_o, .irq_o);
